// ===== src/watchdog_and_reset_flags.sv
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ns

// Notes on behaviour
// - watchdog reset sets its cause flag; power-on or written zero clears it.
// - brown-out reset sets its cause flag; power-on or written zero clears it.
// - pin reset sets its cause flag; power-on or written zero clears it.
// - power-on sets its flag; only a written zero clears it.
// - upper four cause bits read zero.
// - timeout in interrupt operation sets flag; vector or written one clears.
// - interrupt taken only with global enable, irq enable and flag.
// - reset enable and irq enable pick stopped, irq, reset or combined mode.
// - combined mode: vector clears irq enable and flag, leaving reset mode.
// - combined mode: second timeout without vector gives system reset.
// - change unlock clears itself four clock cycles after being set.
// - clearing reset enable or changing period only while unlocked.
// - reset enable reads and acts as one while watchdog cause flag set.
// - period codes 0 to 9 give 2048 to 1048576 oscillator cycles.
// - reserved period codes fall back to a valid period.
// - always-on fuse forces reset mode, enable one, irq enable zero.
// - counter counts oscillator cycles; restart instruction zeroes it.
// - watchdog system reset is a one clock cycle pulse.
module watchdog_and_reset_flags #(
  parameter int unsigned BASE_CYCLES = wdt_pkg::BASE_OSC_CYC
) (
  // clock and reset (power-on)
  input  wire logic                        clk_in,
  input  wire logic                        rst_in,
  // avalon-mm slave
  input  wire logic [wdt_pkg::ADDR_W-1:0]  address_in,
  input  wire logic                        read_in,
  input  wire logic                        write_in,
  input  wire logic [wdt_pkg::DATA_W-1:0]  writedata_in,
  input  wire logic [wdt_pkg::BE_W-1:0]    byteenable_in,
  output logic [wdt_pkg::DATA_W-1:0]       readdata_out,
  output logic                             waitrequest_out,
  // processor side
  input  wire logic                        restart_instr_in,
  input  wire logic                        global_irq_enable_in,
  input  wire logic                        vector_taken_in,
  output logic                             irq_out,
  // reset sources and fuse
  input  wire logic                        brownout_event_in,
  input  wire logic                        pin_reset_event_in,
  input  wire logic                        always_on_fuse_in,
  input  wire logic                        osc_in,
  output logic                             sys_reset_out
);
  import wdt_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                    waitreq;
    logic [DATA_W-1:0]       rdata;
    logic                    fuse_meta;
    logic                    fuse;
    logic                    timeout_irq_flag;
    logic                    timeout_irq_enable;
    logic                    timeout_reset_enable;
    logic [3:0]              period_select;
    logic                    change_unlock;
    logic [UNLOCK_CNT_W-1:0] unlock_cnt;
    logic [CAUSE_N-1:0]      cause;
    logic                    sys_reset;
    logic                    irq;
  } wdt_state_s;

  wdt_state_s         st_ff;
  wdt_state_s         nxt_st;
  logic               timeout;
  logic               ie_eff;
  logic               wde_eff;
  logic               run;
  logic               wr_ctl;
  logic               wr_cause;
  logic               any_reset;
  logic [REG_W-1:0]   wd;
  logic [REG_W-1:0]   ctl_view;
  logic [REG_W-1:0]   cause_view;

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  always_comb begin
    ie_eff  = st_ff.timeout_irq_enable && !st_ff.fuse;
    wde_eff = st_ff.timeout_reset_enable || st_ff.cause[CAUSE_WDT_BIT]
              || st_ff.fuse;
    run     = ie_eff || wde_eff;
  end

  // ----------------------------------------------------------------
  // oscillator counter
  // ----------------------------------------------------------------
  wdt_timebase #(
    .BASE_CYCLES (BASE_CYCLES)
  ) u_timebase (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .osc_in      (osc_in),
    .run_in      (run),
    .restart_in  (restart_instr_in || st_ff.sys_reset),
    .period_in   (st_ff.period_select),
    .timeout_out (timeout)
  );

  // ----------------------------------------------------------------
  // register views
  // ----------------------------------------------------------------
  always_comb begin
    ctl_view = '0;
    ctl_view[CTL_FLAG_BIT]                  = st_ff.timeout_irq_flag;
    ctl_view[CTL_IE_BIT]                    = ie_eff;
    ctl_view[CTL_PS3_BIT]                   = st_ff.period_select[3];
    ctl_view[CTL_UNLK_BIT]                  = st_ff.change_unlock;
    ctl_view[CTL_WDE_BIT]                   = wde_eff;
    ctl_view[CTL_PS_LO_MSB:0]               = st_ff.period_select[2:0];
    cause_view                              = '0;
    cause_view[CAUSE_N-1:0]                 = st_ff.cause;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st           = st_ff;
    nxt_st.fuse_meta = always_on_fuse_in;
    nxt_st.fuse      = st_ff.fuse_meta;
    nxt_st.sys_reset = 1'b0;
    any_reset        = 1'b0;
    wd               = writedata_in[REG_W-1:0];
    wr_ctl   = write_in && !st_ff.waitreq && byteenable_in[LANE_LOW]
               && (address_in == ADDR_CTL);
    wr_cause = write_in && !st_ff.waitreq && byteenable_in[LANE_LOW]
               && (address_in == ADDR_CAUSE);

    // bus handshake: one wait cycle, then the taking edge
    nxt_st.waitreq = 1'b1;
    if ((read_in || write_in) && st_ff.waitreq) begin
      nxt_st.waitreq = 1'b0;
    end
    if (read_in && st_ff.waitreq) begin
      if (address_in == ADDR_CTL) begin
        nxt_st.rdata = {{(DATA_W-REG_W){1'b0}}, ctl_view};
      end else if (address_in == ADDR_CAUSE) begin
        nxt_st.rdata = {{(DATA_W-REG_W){1'b0}}, cause_view};
      end else begin
        nxt_st.rdata = RDATA_RESET;
      end
    end

    // unlock window countdown
    if (st_ff.change_unlock) begin
      if (st_ff.unlock_cnt == '0) begin
        nxt_st.change_unlock = 1'b0;
      end else begin
        nxt_st.unlock_cnt = st_ff.unlock_cnt - UNLOCK_CNT_W'(1);
      end
    end

    // control register write
    if (wr_ctl) begin
      if (wd[CTL_FLAG_BIT]) begin
        nxt_st.timeout_irq_flag = 1'b0;
      end
      nxt_st.timeout_irq_enable = wd[CTL_IE_BIT];
      if (st_ff.change_unlock) begin
        nxt_st.timeout_reset_enable = wd[CTL_WDE_BIT];
        nxt_st.period_select = {wd[CTL_PS3_BIT], wd[CTL_PS_LO_MSB:0]};
        nxt_st.change_unlock = wd[CTL_UNLK_BIT];
        if (wd[CTL_UNLK_BIT]) begin
          nxt_st.unlock_cnt = UNLOCK_LOAD;
        end
      end else begin
        // locked: reset enable may only be set
        nxt_st.timeout_reset_enable = st_ff.timeout_reset_enable
                                      || wd[CTL_WDE_BIT];
        if (wd[CTL_UNLK_BIT]) begin
          nxt_st.change_unlock = 1'b1;
          nxt_st.unlock_cnt    = UNLOCK_LOAD;
        end
      end
    end

    // vector execution
    if (vector_taken_in) begin
      nxt_st.timeout_irq_flag = 1'b0;
      if (wde_eff) begin
        nxt_st.timeout_irq_enable = 1'b0;
      end
    end

    // timeout action, set wins over clear
    if (timeout) begin
      if (wde_eff && (!ie_eff || st_ff.timeout_irq_flag)) begin
        nxt_st.sys_reset = 1'b1;
      end else if (ie_eff) begin
        nxt_st.timeout_irq_flag = 1'b1;
      end
    end

    // reset cause flags: written zero clears, events set
    if (wr_cause) begin
      for (int i = 0; i < CAUSE_N; i++) begin
        if (!wd[i]) begin
          nxt_st.cause[i] = 1'b0;
        end
      end
    end
    if (st_ff.sys_reset) begin
      nxt_st.cause[CAUSE_WDT_BIT] = 1'b1;
      any_reset = 1'b1;
    end
    if (brownout_event_in) begin
      nxt_st.cause[CAUSE_BOR_BIT] = 1'b1;
      any_reset = 1'b1;
    end
    if (pin_reset_event_in) begin
      nxt_st.cause[CAUSE_EXT_BIT] = 1'b1;
      any_reset = 1'b1;
    end

    // system reset reinitialises control; power-on flag untouched
    if (any_reset) begin
      nxt_st.timeout_irq_flag     = 1'b0;
      nxt_st.timeout_irq_enable   = 1'b0;
      nxt_st.timeout_reset_enable = 1'b0;
      nxt_st.period_select        = PERIOD_RESET;
      nxt_st.change_unlock        = 1'b0;
      nxt_st.unlock_cnt           = '0;
    end

    // watchdog cause flag pins the stored reset enable high
    if (nxt_st.cause[CAUSE_WDT_BIT]) begin
      nxt_st.timeout_reset_enable = 1'b1;
    end

    nxt_st.irq = st_ff.timeout_irq_flag && ie_eff && global_irq_enable_in;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff                      <= '0;
      st_ff.waitreq              <= 1'b1;
      st_ff.cause                <= CAUSE_POR_RESET;
      st_ff.period_select        <= PERIOD_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign readdata_out    = st_ff.rdata;
  assign waitrequest_out = st_ff.waitreq;
  assign irq_out         = st_ff.irq;
  assign sys_reset_out   = st_ff.sys_reset;

endmodule // watchdog_and_reset_flags

// ===== inc/wdt_pkg.sv
package wdt_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned BE_W        = 4;
  localparam int unsigned REG_W       = 8;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CTL   = 8'h60;
  localparam logic [ADDR_W-1:0] ADDR_CAUSE = 8'h64;
  localparam int unsigned       LANE_LOW   = 0;

  // ----------------------------------------------------------------
  // watchdog_control_status fields
  // ----------------------------------------------------------------
  localparam int unsigned CTL_FLAG_BIT  = 7;
  localparam int unsigned CTL_IE_BIT    = 6;
  localparam int unsigned CTL_PS3_BIT   = 5;
  localparam int unsigned CTL_UNLK_BIT  = 4;
  localparam int unsigned CTL_WDE_BIT   = 3;
  localparam int unsigned CTL_PS_LO_MSB = 2;

  // ----------------------------------------------------------------
  // reset_cause_status fields
  // ----------------------------------------------------------------
  localparam int unsigned CAUSE_POR_BIT = 0;
  localparam int unsigned CAUSE_EXT_BIT = 1;
  localparam int unsigned CAUSE_BOR_BIT = 2;
  localparam int unsigned CAUSE_WDT_BIT = 3;
  localparam int unsigned CAUSE_N       = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [CAUSE_N-1:0] CAUSE_POR_RESET = 4'h1;
  localparam logic [3:0]         PERIOD_RESET    = 4'h0;
  localparam logic [DATA_W-1:0]  RDATA_RESET     = 32'h0000_0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned OSC_FREQ_KHZ   = 128;
  localparam int unsigned BASE_OSC_CYC   = 2048;
  localparam int unsigned UNLOCK_N_CYC   = 4;
  localparam int unsigned UNLOCK_CNT_W   = 3;
  localparam logic [UNLOCK_CNT_W-1:0] UNLOCK_LOAD = 3'(UNLOCK_N_CYC - 1);
  localparam logic [3:0]  PERIOD_MAX     = 4'h9;
  localparam int unsigned WDT_CNT_W      = 21;

endpackage

// ===== src/wdt_timebase.sv
`timescale 1ns/1ns

module wdt_timebase #(
  parameter int unsigned BASE_CYCLES = wdt_pkg::BASE_OSC_CYC
) (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // oscillator pin
  input  wire logic       osc_in,
  // control
  input  wire logic       run_in,
  input  wire logic       restart_in,
  input  wire logic [3:0] period_in,
  // event
  output logic            timeout_out
);
  import wdt_pkg::*;

  typedef struct packed {
    logic                 osc_meta;
    logic                 osc_sync;
    logic                 osc_prev;
    logic [WDT_CNT_W-1:0] cnt;
    logic                 timeout;
  } tb_state_s;

  tb_state_s            st_ff;
  tb_state_s            nxt_st;
  logic [3:0]           eff_period;
  logic [WDT_CNT_W-1:0] limit;

  // ----------------------------------------------------------------
  // period decode and counter
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.osc_meta = osc_in;
    nxt_st.osc_sync = st_ff.osc_meta;
    nxt_st.osc_prev = st_ff.osc_sync;
    nxt_st.timeout  = 1'b0;
    // reserved codes fall back to the longest valid period
    eff_period = (period_in > PERIOD_MAX) ? PERIOD_MAX : period_in;
    limit      = WDT_CNT_W'(BASE_CYCLES) << eff_period;
    if (restart_in || !run_in) begin
      nxt_st.cnt = '0;
    end else if (st_ff.osc_sync && !st_ff.osc_prev) begin
      // >= so a shortened period expires on the next oscillator edge
      if (st_ff.cnt >= limit - WDT_CNT_W'(1)) begin
        nxt_st.cnt     = '0;
        nxt_st.timeout = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + WDT_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign timeout_out = st_ff.timeout;

endmodule // wdt_timebase

// ===== test/wdt_properties.sv
`timescale 1ns/1ns
module wdt_properties
  import wdt_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = wdt_pkg::BASE_OSC_CYC
) (
  // clock and reset
  input wire logic              clk_in,
  input wire logic              rst_in,
  // register bus
  input wire logic [ADDR_W-1:0] address_in,
  input wire logic              read_in,
  input wire logic              write_in,
  input wire logic [DATA_W-1:0] writedata_in,
  input wire logic [BE_W-1:0]   byteenable_in,
  input wire logic [DATA_W-1:0] readdata_out,
  input wire logic              waitrequest_out,
  // processor side
  input wire logic              restart_instr_in,
  input wire logic              global_irq_enable_in,
  input wire logic              vector_taken_in,
  input wire logic              irq_out,
  // reset sources and fuse
  input wire logic              brownout_event_in,
  input wire logic              pin_reset_event_in,
  input wire logic              always_on_fuse_in,
  input wire logic              osc_in,
  input wire logic              sys_reset_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_wait_answer: assert property ((read_in || write_in) && waitrequest_out |=> !waitrequest_out)
    else $error("request not answered after one wait cycle");
  a_wait_single: assert property (!waitrequest_out |=> waitrequest_out)
    else $error("waitrequest low longer than one cycle");
  a_rdata_high: assert property (!waitrequest_out |-> readdata_out[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  a_unmapped_zero: assert property (read_in && waitrequest_out && address_in != ADDR_CTL
    && address_in != ADDR_CAUSE |=> readdata_out == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_cause_upper: assert property (read_in && waitrequest_out && address_in == ADDR_CAUSE
    |=> readdata_out[7:4] == 4'h0)
    else $error("cause register upper bits not zero");
  a_sysrst_pulse: assert property (sys_reset_out |=> !sys_reset_out)
    else $error("system reset longer than one cycle");
  a_irq_global: assert property (irq_out |-> $past(global_irq_enable_in))
    else $error("interrupt without global enable");
  a_vector_clears: assert property (vector_taken_in |-> ##2 !irq_out)
    else $error("interrupt still pending after vector");
  a_fuse_forces: assert property (read_in && waitrequest_out && address_in == ADDR_CTL
    && always_on_fuse_in && $past(always_on_fuse_in, 4) |=> readdata_out[3] && !readdata_out[6])
    else $error("fuse does not force reset mode");
endmodule // wdt_properties

bind watchdog_and_reset_flags wdt_properties #(.BASE_CYCLES(BASE_CYCLES)) u_props (
  .clk_in(clk_in), .rst_in(rst_in), .address_in(address_in), .read_in(read_in),
  .write_in(write_in), .writedata_in(writedata_in), .byteenable_in(byteenable_in),
  .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
  .restart_instr_in(restart_instr_in), .global_irq_enable_in(global_irq_enable_in),
  .vector_taken_in(vector_taken_in), .irq_out(irq_out),
  .brownout_event_in(brownout_event_in), .pin_reset_event_in(pin_reset_event_in),
  .always_on_fuse_in(always_on_fuse_in), .osc_in(osc_in), .sys_reset_out(sys_reset_out));

// ===== test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import wdt_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk_in = 0, rst_in = 1, read_in = 0, write_in = 0;
  logic [7:0]  address_in = 8'h00;
  logic [31:0] writedata_in = 32'h0000_0000;
  logic [3:0]  byteenable_in = 4'h0;
  logic [31:0] readdata_out, q;
  logic        waitrequest_out, irq_out, sys_reset_out, osc_in = 0;
  logic        restart_instr_in = 0, global_irq_enable_in = 0, vector_taken_in = 0;
  logic        brownout_event_in = 0, pin_reset_event_in = 0, always_on_fuse_in = 0;
  logic [2:0]  osc_div = 3'h0;
  logic [3:0]  codes[3] = '{4'hA, 4'h1, 4'h0};
  int          n_mismatch = 0, check_count = 0, n_rst = 0, n, k;

  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    osc_div <= osc_div + 3'h1;
    osc_in <= osc_div[2];
    if (sys_reset_out === 1'b1) n_rst <= n_rst + 1;
  end

  watchdog_and_reset_flags #(.BASE_CYCLES(4)) u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .address_in(address_in), .read_in(read_in),
    .write_in(write_in), .writedata_in(writedata_in), .byteenable_in(byteenable_in),
    .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
    .restart_instr_in(restart_instr_in), .global_irq_enable_in(global_irq_enable_in),
    .vector_taken_in(vector_taken_in), .irq_out(irq_out),
    .brownout_event_in(brownout_event_in), .pin_reset_event_in(pin_reset_event_in),
    .always_on_fuse_in(always_on_fuse_in), .osc_in(osc_in), .sys_reset_out(sys_reset_out));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int i;
    i = 0;
    @(posedge clk_in);
    read_in <= !w;
    write_in <= w;
    address_in <= a;
    writedata_in <= d;
    byteenable_in <= be;
    do begin
      @(posedge clk_in);
      i++;
    end while (waitrequest_out !== 1'b0 && i < 20);
    q = readdata_out;
    read_in <= 1'b0;
    write_in <= 1'b0;
    if (waitrequest_out !== 1'b0) begin
      n_mismatch++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, a, {24'h00_0000, d}, 4'h1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    acc(1'b0, a, 32'h0000_0000, 4'h1);
    chk(nm, q, {24'h00_0000, e});
  endtask

  task automatic pulse(input int p);
    @(posedge clk_in);
    case (p)
      0: restart_instr_in <= 1'b1;
      1: vector_taken_in <= 1'b1;
      2: brownout_event_in <= 1'b1;
      default: pin_reset_event_in <= 1'b1;
    endcase
    @(posedge clk_in);
    {restart_instr_in, vector_taken_in, brownout_event_in, pin_reset_event_in} <= 4'h0;
  endtask

  task automatic waitfor(input bit rs, input int lim);
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while ((rs ? sys_reset_out : irq_out) !== 1'b1 && n < lim);
    if ((rs ? sys_reset_out : irq_out) !== 1'b1) begin
      n_mismatch++;
      end_sim();
    end
  endtask

  function automatic logic [7:0] pbits(input logic [3:0] c);
    return {2'b00, c[3], 2'b00, c[2:0]};
  endfunction

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(ADDR_CTL, 8'h00, "ctl");
    rd(ADDR_CAUSE, 8'h01, "cause");
    rd(8'h70, 8'h00, "unmapped");
    repeat (100) @(posedge clk_in);
    chk("resets", n_rst, 0);
    $display("reset test done");
    pulse(2);
    pulse(3);
    rd(ADDR_CAUSE, 8'h07, "cause");
    wr(ADDR_CAUSE, 8'hFD);
    rd(ADDR_CAUSE, 8'h05, "cause");
    wr(ADDR_CAUSE, 8'hF0);
    rd(ADDR_CAUSE, 8'h00, "cause");
    $display("cause test done");
    wr(ADDR_CTL, 8'h08);
    wr(ADDR_CTL, 8'h07);
    rd(ADDR_CTL, 8'h08, "ctl");
    acc(1'b1, ADDR_CTL, 32'h0000_0010, 4'h0);
    wr(ADDR_CTL, 8'h00);
    rd(ADDR_CTL, 8'h08, "ctl");
    wr(ADDR_CTL, 8'h18);
    wr(ADDR_CTL, 8'h25);
    rd(ADDR_CTL, 8'h25, "ctl");
    wr(ADDR_CTL, 8'h18);
    repeat (6) @(posedge clk_in);
    rd(ADDR_CTL, 8'h2D, "ctl");
    wr(ADDR_CTL, 8'h00);
    rd(ADDR_CTL, 8'h2D, "ctl");
    wr(ADDR_CTL, 8'h10);
    wr(ADDR_CTL, 8'h00);
    rd(ADDR_CTL, 8'h00, "ctl");
    $display("protection test done");
    global_irq_enable_in <= 1'b1;
    foreach (codes[j]) begin
      pulse(0);
      wr(ADDR_CTL, 8'h10);
      wr(ADDR_CTL, 8'h40 | pbits(codes[j]));
      wr(ADDR_CTL, 8'hC0);
      pulse(0);
      waitfor(0, 20000);
      k = (codes[j] > 4'h9) ? (4 << 9) : (4 << codes[j]);
      chk("period", n >= (k - 1) * 8 && n <= k * 8 + 8, 1);
    end
    wr(ADDR_CTL, 8'hC0);
    repeat (2) @(posedge clk_in);
    waitfor(0, 48);
    global_irq_enable_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk("irq", irq_out, 0);
    rd(ADDR_CTL, 8'hC0, "ctl");
    global_irq_enable_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk("irq", irq_out, 1);
    pulse(1);
    rd(ADDR_CTL, 8'h40, "ctl");
    chk("resets", n_rst, 0);
    $display("interrupt test done");
    wr(ADDR_CTL, 8'hC8);
    pulse(0);
    waitfor(0, 64);
    chk("resets", n_rst, 0);
    pulse(1);
    rd(ADDR_CTL, 8'h08, "ctl");
    waitfor(1, 48);
    rd(ADDR_CTL, 8'h08, "ctl");
    wr(ADDR_CTL, 8'h18);
    wr(ADDR_CTL, 8'h00);
    rd(ADDR_CTL, 8'h08, "ctl");
    rd(ADDR_CAUSE, 8'h08, "cause");
    wr(ADDR_CAUSE, 8'h00);
    wr(ADDR_CTL, 8'h18);
    wr(ADDR_CTL, 8'h00);
    rd(ADDR_CTL, 8'h00, "ctl");
    wr(ADDR_CTL, 8'h48);
    pulse(0);
    waitfor(0, 64);
    waitfor(1, 48);
    rd(ADDR_CAUSE, 8'h08, "cause");
    wr(ADDR_CAUSE, 8'h00);
    wr(ADDR_CTL, 8'h18);
    wr(ADDR_CTL, 8'h00);
    rd(ADDR_CTL, 8'h00, "ctl");
    chk("resets", n_rst, 2);
    $display("combined test done");
    always_on_fuse_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    acc(1'b0, ADDR_CTL, 32'h0000_0000, 4'h1);
    chk("fuse", q & 32'h0000_0048, 32'h0000_0008);
    waitfor(1, 80);
    $display("fuse test done");
    end_sim();
  end
endmodule // tb_top
